/* rcrtm_pkg.sv */
// Shared constants, register layout and types of the receive clock recovery and test mux block.
// Assumes a single 20 MHz clock and a synchronous active-high reset.
package rcrtm_pkg;

  // ****************************************
  // Clock and timing
  // ****************************************
  localparam int CLK_HZ = 20_000_000;
  localparam int RST_DELAY_MS = 300;
  localparam int TX_TIMEOUT_MS = 3000;
  localparam int RST_DELAY_CYC = RST_DELAY_MS * (CLK_HZ / 1000);
  localparam int TX_TIMEOUT_CYC = TX_TIMEOUT_MS * (CLK_HZ / 1000);
  localparam int SHORT_FACTOR = 256;
  localparam int SAMPLES_PER_BIT = 16;
  localparam logic [11:0] DIV_600 = 12'(CLK_HZ / (600 * SAMPLES_PER_BIT));
  localparam logic [11:0] DIV_1200 = 12'(CLK_HZ / (1200 * SAMPLES_PER_BIT));
  localparam logic [11:0] DIV_2400 = 12'(CLK_HZ / (2400 * SAMPLES_PER_BIT));
  localparam logic [3:0] PHASE_SAMPLE = 4'h8;

  // ****************************************
  // Demodulator and data filter
  // ****************************************
  localparam int IF_PERIOD_D0 = CLK_HZ / 2700;
  localparam int IF_PERIOD_D1 = CLK_HZ / 5400;
  localparam int STEP_SHIFT_D0 = 7;
  localparam int STEP_SHIFT_D1 = 6;
  localparam logic [15:0] PRESET_D0 = 16'((8 << STEP_SHIFT_D0) - IF_PERIOD_D0);
  localparam logic [15:0] PRESET_D1 = 16'((8 << STEP_SHIFT_D1) - IF_PERIOD_D1);
  localparam int DF_SHIFT = 2;
  localparam logic [7:0] DF_HYST_HI = 8'h88;
  localparam logic [7:0] DF_HYST_LO = 8'h78;

  // ****************************************
  // Register map
  // ****************************************
  localparam logic [7:0] OFS_TEST = 8'h00;
  localparam logic [7:0] OFS_SETUP = 8'h04;
  localparam logic [7:0] OFS_STATUS = 8'h08;
  localparam logic [7:0] OFS_RXDATA = 8'h0C;
  localparam int STATUS_OVERRUN_BIT = 5;
  localparam int FIFO_DEPTH = 8;
  localparam int FIFO_WIDTH = 8;

  typedef struct packed {
    logic observeKeepBit;
    logic asyncSelectBit;
    logic testSelHi;
    logic testSelLo;
  } rcrtm_test_t;

  typedef struct packed {
    logic [1:0] rxBaudRate;
    logic rxBandwidthA;
    logic baudSelectBit;
    logic modDepthBit;
    logic markMsb;
    logic powerDownBit;
    logic supervisionOptionBit;
    logic zeroCrossEnable;
    logic rxBandwidthB;
    logic [7:0] markLow;
  } rcrtm_setup_t;

  localparam rcrtm_test_t TEST_RST = 4'h0;
  localparam rcrtm_setup_t SETUP_RST = 18'h1F2C5;

  typedef enum logic [1:0] {
    MUX_NORMAL = 2'b00,
    MUX_IF = 2'b01,
    MUX_TXPATH = 2'b10,
    MUX_DPLL = 2'b11
  } rcrtm_mux_t;

endpackage : rcrtm_pkg

/* rcrtm_top.sv */
// Receive clock recovery, demodulator word, data selectors, test mux and timers, APB slave.
// Assumes 20 MHz clk, synchronous reset, and analog-side signals arriving asynchronously.
//
// The address map and the APB slave port were chosen for this implementation.

// ****************************************
// Receive word FIFO
// ****************************************
module rcrtm_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [AW:0] wrPtr_ff;
  logic [AW:0] rdPtr_ff;
  wire logic push = inValid && inReady;
  wire logic pop = outValid && outReady;

  assign inReady = (wrPtr_ff[AW] == rdPtr_ff[AW]) || (wrPtr_ff[AW-1:0] != rdPtr_ff[AW-1:0]);
  assign outValid = wrPtr_ff != rdPtr_ff;
  assign outData = mem_ff[rdPtr_ff[AW-1:0]];

  always_ff @(posedge clk) begin
    if (push) begin
      mem_ff[wrPtr_ff[AW-1:0]] <= inData;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      wrPtr_ff <= '0;
      rdPtr_ff <= '0;
    end else begin
      wrPtr_ff <= wrPtr_ff + (AW+1)'(push);
      rdPtr_ff <= rdPtr_ff + (AW+1)'(pop);
    end
  end
endmodule : rcrtm_fifo

module rcrtm_top #(
  parameter int RST_DELAY = rcrtm_pkg::RST_DELAY_CYC,
  parameter int TX_TIMEOUT = rcrtm_pkg::TX_TIMEOUT_CYC
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic ifCompIn,
  input wire logic testInputPin,
  input wire logic txModeIn,
  input wire logic supplyLowIn,
  input wire logic lockBondedLowIn,
  input wire logic switchedCapClockIn,
  input wire logic mixerRefClockIn,
  output logic rxDataOut,
  output logic rxtxClockOut,
  output logic systemClockOut,
  output rcrtm_pkg::rcrtm_mux_t testOutputSel,
  output rcrtm_pkg::rcrtm_mux_t testInputRoute,
  output logic testInputEnable,
  output logic supplyResetNOut,
  output logic supplyResetNOe,
  output logic txTimeoutOut
);
  import rcrtm_pkg::*;

  // ****************************************
  // Input synchronisers
  // ****************************************
  localparam int NSYNC = 7;
  wire logic [NSYNC-1:0] pinsRaw = {mixerRefClockIn, switchedCapClockIn, lockBondedLowIn,
                                    supplyLowIn, txModeIn, testInputPin, ifCompIn};
  logic [NSYNC-1:0] meta_ff;
  logic [NSYNC-1:0] sync_ff;
  genvar gi;
  generate
    for (gi = 0; gi < NSYNC; gi++) begin : g_sync
      always_ff @(posedge clk) begin
        if (rst) begin
          meta_ff[gi] <= 1'b0;
          sync_ff[gi] <= 1'b0;
        end else begin
          meta_ff[gi] <= pinsRaw[gi];
          sync_ff[gi] <= meta_ff[gi];
        end
      end
    end
  endgenerate
  wire logic ifSync = sync_ff[0];
  wire logic testInSync = sync_ff[1];
  wire logic txModeSync = sync_ff[2];
  wire logic supplyLowSync = sync_ff[3];
  wire logic lockSync = sync_ff[4];
  wire logic scClkSync = sync_ff[5];
  wire logic mixClkSync = sync_ff[6];

  // ****************************************
  // Registers and test decode
  // ****************************************
  rcrtm_test_t testReg_ff;
  rcrtm_setup_t setupReg_ff;
  wire rcrtm_mux_t muxState = rcrtm_mux_t'({testReg_ff.testSelHi, testReg_ff.testSelLo});
  wire logic tinActive = !testReg_ff.observeKeepBit;
  wire logic bypass = (muxState == MUX_NORMAL) && tinActive && testInSync;

  // ****************************************
  // Demodulator period counter
  // ****************************************
  logic ifPrev_ff;
  logic [15:0] perCnt_ff;
  logic [3:0] demodCode_ff;
  wire logic ifRise = ifSync && !ifPrev_ff;
  wire logic [15:0] preset = setupReg_ff.modDepthBit ? PRESET_D1 : PRESET_D0;
  wire logic [15:0] scaled = setupReg_ff.modDepthBit ? (perCnt_ff >> STEP_SHIFT_D1)
                                                     : (perCnt_ff >> STEP_SHIFT_D0);
  // deviation code, clipped to four bits
  wire logic [3:0] codeNow = perCnt_ff[15] ? 4'h0 : (scaled > 16'h000F) ? 4'hF : scaled[3:0];

  always_ff @(posedge clk) begin
    if (rst) begin
      ifPrev_ff <= 1'b0;
      perCnt_ff <= PRESET_D0;
      demodCode_ff <= 4'h8;
    end else begin
      ifPrev_ff <= ifSync;
      perCnt_ff <= ifRise ? preset : perCnt_ff + 16'h0001;
      demodCode_ff <= ifRise ? codeNow : demodCode_ff;
    end
  end

  // ****************************************
  // Sample tick and data filter
  // ****************************************
  logic [11:0] divCnt_ff;
  logic [7:0] dfAcc_ff;
  logic dfBit_ff;
  wire logic [11:0] divLimit = (setupReg_ff.rxBaudRate == 2'b00) ? DIV_600 :
                               (setupReg_ff.rxBaudRate == 2'b01) ? DIV_1200 : DIV_2400;
  wire logic tick = divCnt_ff >= divLimit - 12'h001;
  wire logic [7:0] dfIn = {demodCode_ff, 4'h0};
  // Nine-bit difference, no wrap on large swings
  wire logic signed [8:0] dfDiff = $signed({1'b0, dfIn}) - $signed({1'b0, dfAcc_ff});
  wire logic [7:0] dfStep = 8'(dfDiff >>> DF_SHIFT);

  always_ff @(posedge clk) begin
    if (rst) begin
      divCnt_ff <= 12'h000;
      dfAcc_ff <= 8'h80;
      dfBit_ff <= 1'b0;
    end else begin
      divCnt_ff <= tick ? 12'h000 : divCnt_ff + 12'h001;
      dfAcc_ff <= tick ? dfAcc_ff + dfStep : dfAcc_ff;
      dfBit_ff <= (dfAcc_ff > DF_HYST_HI) ? 1'b1 : (dfAcc_ff < DF_HYST_LO) ? 1'b0 : dfBit_ff;
    end
  end

  // ****************************************
  // Clock recovery PLL
  // ****************************************
  logic [3:0] phase_ff;
  logic pllPrev_ff;
  logic syncRx_ff;
  logic [3:0] txPhase_ff;
  wire logic pllIn = (muxState == MUX_DPLL && tinActive) ? testInSync : dfBit_ff;
  wire logic pllEdge = pllIn != pllPrev_ff;
  wire logic [3:0] phaseStep = !pllEdge ? 4'h1 : (phase_ff == 4'h0) ? 4'h1 :
                               (phase_ff < PHASE_SAMPLE) ? 4'h2 : 4'h0;
  // clock rises four ticks after resample
  wire logic recClk = !(phase_ff[3] ^ phase_ff[2]);
  wire logic txClk = !txPhase_ff[3];

  // phase nudged by data edges, resample mid-bit
  always_ff @(posedge clk) begin
    if (rst) begin
      phase_ff <= 4'h0;
      pllPrev_ff <= 1'b0;
      syncRx_ff <= 1'b0;
      txPhase_ff <= 4'h0;
    end else if (tick) begin
      phase_ff <= phase_ff + phaseStep;
      pllPrev_ff <= pllIn;
      syncRx_ff <= (phase_ff == PHASE_SAMPLE) ? pllIn : syncRx_ff;
      txPhase_ff <= txPhase_ff + 4'h1;
    end
  end

  // ****************************************
  // Output selectors
  // ****************************************
  logic rxData_ff;
  logic rxtxClk_ff;
  logic sysClk_ff;
  rcrtm_mux_t muxOut_ff;
  wire logic sysClkSel = (muxState == MUX_NORMAL) ? !sysClk_ff :
                         (muxState == MUX_IF) ? ifSync :
                         (muxState == MUX_TXPATH) ? scClkSync : mixClkSync;

  always_ff @(posedge clk) begin
    if (rst) begin
      rxData_ff <= 1'b0;
      rxtxClk_ff <= 1'b0;
      sysClk_ff <= 1'b0;
      muxOut_ff <= MUX_NORMAL;
    end else begin
      rxData_ff <= testReg_ff.asyncSelectBit ? pllIn : syncRx_ff;
      rxtxClk_ff <= txModeSync ? recClk : txClk;
      sysClk_ff <= sysClkSel;
      muxOut_ff <= muxState;
    end
  end
  assign rxDataOut = rxData_ff;
  assign rxtxClockOut = rxtxClk_ff;
  assign systemClockOut = sysClk_ff;
  assign testOutputSel = muxOut_ff;
  assign testInputRoute = muxOut_ff;
  assign testInputEnable = tinActive;

  // ****************************************
  // Reset delay and transmit timeout
  // ****************************************
  logic [22:0] rstCnt_ff;
  logic [25:0] txCnt_ff;
  logic resetOe_ff;
  logic txTimeout_ff;
  wire logic [22:0] rstLimit = testReg_ff.testSelHi ? 23'(RST_DELAY / SHORT_FACTOR)
                                                    : 23'(RST_DELAY);
  wire logic [25:0] txLimit = testReg_ff.testSelHi ? 26'(TX_TIMEOUT / SHORT_FACTOR)
                                                   : 26'(TX_TIMEOUT);
  wire logic rstDone = bypass || (rstCnt_ff >= rstLimit - 23'h1);
  wire logic txDone = !bypass && (txCnt_ff >= txLimit - 26'h1);

  always_ff @(posedge clk) begin
    if (rst) begin
      rstCnt_ff <= 23'h0;
      txCnt_ff <= 26'h0;
      resetOe_ff <= 1'b1;
      txTimeout_ff <= 1'b0;
    end else begin
      rstCnt_ff <= supplyLowSync ? 23'h0 : rstDone ? rstCnt_ff : rstCnt_ff + 23'h1;
      // low while supply low or delay running
      resetOe_ff <= supplyLowSync || !rstDone;
      txCnt_ff <= (txModeSync || txDone) ? txCnt_ff & {26{!txModeSync}} : txCnt_ff + 26'h1;
      txTimeout_ff <= !txModeSync && txDone;
    end
  end
  assign supplyResetNOut = 1'b0;
  assign supplyResetNOe = resetOe_ff;
  assign txTimeoutOut = txTimeout_ff;

  // ****************************************
  // Receive byte assembly and FIFO
  // ****************************************
  logic [7:0] shReg_ff;
  logic [2:0] bitCnt_ff;
  logic wordValid_ff;
  logic overrun_ff;
  logic fifoInReady;
  logic fifoOutValid;
  logic [7:0] fifoOutData;
  logic fifoPop;
  logic ovrClear;
  wire logic bitTick = tick && phase_ff == PHASE_SAMPLE && txModeSync;
  wire logic bitLost = bitTick && wordValid_ff && !fifoInReady;

  always_ff @(posedge clk) begin
    if (rst) begin
      shReg_ff <= 8'h00;
      bitCnt_ff <= 3'h0;
      wordValid_ff <= 1'b0;
      overrun_ff <= 1'b0;
    end else begin
      if (bitTick && !(wordValid_ff && !fifoInReady)) begin
        shReg_ff <= {pllIn, shReg_ff[7:1]};
        bitCnt_ff <= bitCnt_ff + 3'h1;
      end
      wordValid_ff <= (bitTick && bitCnt_ff == 3'h7) || (wordValid_ff && !fifoInReady);
      overrun_ff <= bitLost || (overrun_ff && !ovrClear);
    end
  end

  rcrtm_fifo #(.WIDTH(FIFO_WIDTH), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk(clk),
    .rst(rst),
    .inValid(wordValid_ff),
    .inReady(fifoInReady),
    .inData(shReg_ff),
    .outValid(fifoOutValid),
    .outReady(fifoPop),
    .outData(fifoOutData)
  );

  // ****************************************
  // APB slave
  // ****************************************
  function automatic logic isMapped(input logic [7:0] a);
    return a == OFS_TEST || a == OFS_SETUP || a == OFS_STATUS || a == OFS_RXDATA;
  endfunction

  logic [31:0] prdata_ff;
  wire logic access = psel && penable;
  // locked part writes only test register
  wire logic lockBlock = pwrite && lockSync && paddr != OFS_TEST;
  wire logic busErr = !isMapped(paddr) || lockBlock;
  wire logic wrOk = access && pwrite && !busErr;
  wire logic [31:0] statusWord = {21'h0, dfBit_ff, muxState, txTimeout_ff, lockSync,
                                  overrun_ff, fifoOutValid, demodCode_ff};
  wire logic [31:0] rdWord = (paddr == OFS_TEST) ? {28'h0, testReg_ff} :
                             (paddr == OFS_SETUP) ? {14'h0, setupReg_ff} :
                             (paddr == OFS_STATUS) ? statusWord :
                             (paddr == OFS_RXDATA) ? {23'h0, fifoOutValid, fifoOutData} : 32'h0;
  assign pready = access;
  assign pslverr = access && busErr;
  assign prdata = prdata_ff;
  assign fifoPop = access && !pwrite && paddr == OFS_RXDATA;
  assign ovrClear = wrOk && paddr == OFS_STATUS && pwdata[STATUS_OVERRUN_BIT];

  always_ff @(posedge clk) begin
    if (rst) begin
      prdata_ff <= 32'h0;
      testReg_ff <= TEST_RST;
      setupReg_ff <= SETUP_RST;
    end else begin
      prdata_ff <= (psel && !penable && !pwrite) ? rdWord : prdata_ff;
      testReg_ff <= (wrOk && paddr == OFS_TEST) ? rcrtm_test_t'(pwdata[3:0]) : testReg_ff;
      setupReg_ff <= (wrOk && paddr == OFS_SETUP) ? rcrtm_setup_t'(pwdata[17:0]) : setupReg_ff;
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  property p_resample;
    @(posedge clk) disable iff (rst) tick && phase_ff == PHASE_SAMPLE |=> syncRx_ff == $past(pllIn);
  endproperty
  a_resample: assert property (p_resample) else $error("resampled bit wrong");

  property p_rx_mux;
    @(posedge clk) disable iff (rst)
      testReg_ff.asyncSelectBit ##1 testReg_ff.asyncSelectBit |-> rxDataOut == $past(pllIn);
  endproperty
  a_rx_mux: assert property (p_rx_mux) else $error("raw data not routed");

  property p_clk_mux;
    @(posedge clk) disable iff (rst) !txModeSync |=> rxtxClockOut == $past(txClk);
  endproperty
  a_clk_mux: assert property (p_clk_mux) else $error("transmit clock not routed");

  property p_sync_stable;
    @(posedge clk) disable iff (rst)
      $rose(rxtxClockOut) && $past(txModeSync, 2) && $past(!testReg_ff.asyncSelectBit, 2)
      |-> $stable(rxDataOut);
  endproperty
  a_sync_stable: assert property (p_sync_stable) else $error("data moved at clock rise");

  property p_decode;
    @(posedge clk) disable iff (rst)
      1'b1 |=> testOutputSel == {$past(testReg_ff.testSelHi), $past(testReg_ff.testSelLo)};
  endproperty
  a_decode: assert property (p_decode) else $error("mux state decode wrong");

  property p_bypass;
    @(posedge clk) disable iff (rst) bypass && !supplyLowSync |=> !supplyResetNOe && !txTimeoutOut;
  endproperty
  a_bypass: assert property (p_bypass) else $error("timers not bypassed");

  property p_short;
    @(posedge clk) disable iff (rst)
      $fell(supplyResetNOe) |-> $past(bypass) || $past(rstCnt_ff) == $past(rstLimit) - 23'h1;
  endproperty
  a_short: assert property (p_short) else $error("reset delay length wrong");

  property p_sysclk;
    @(posedge clk) disable iff (rst)
      muxState == MUX_NORMAL |=> systemClockOut == !$past(systemClockOut);
  endproperty
  a_sysclk: assert property (p_sysclk) else $error("system clock not halved");

  property p_lock;
    @(posedge clk) disable iff (rst)
      access && lockBlock |-> pslverr ##1 setupReg_ff == $past(setupReg_ff);
  endproperty
  a_lock: assert property (p_lock) else $error("locked write took effect");

endmodule : rcrtm_top

/* rcrtm_host_model.sv */
// Host model: picks receive bits on the rising receive clock.
// Assumes registered data and clock outputs in the clk domain.
module rcrtm_host_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic receiveReq,
  input wire logic rxData,
  input wire logic rxtxClock,
  output logic txModeIn,
  output logic [15:0] history,
  output logic [7:0] sampleCount,
  output logic [7:0] stableErrs
);
  logic clkPrev;
  logic dataPrev;
  assign txModeIn = receiveReq;
  always_ff @(posedge clk) begin
    if (rst) begin
      clkPrev <= 1'b0;
      dataPrev <= 1'b0;
      history <= 16'h0000;
      sampleCount <= 8'h00;
      stableErrs <= 8'h00;
    end else begin
      clkPrev <= rxtxClock;
      dataPrev <= rxData;
      if (rxtxClock && !clkPrev && txModeIn) begin
        history <= {rxData, history[15:1]};
        sampleCount <= sampleCount + 8'h01;
        if (rxData !== dataPrev) begin
          stableErrs <= stableErrs + 8'h01;
        end
      end
    end
  end
endmodule : rcrtm_host_model

/* rx_clock_recovery_test_mux_tb_top.sv */
// Testbench of the receive clock recovery and test mux block.
// Assumes shortened timer parameters and the host model beside it.
`define CHK(g, e) begin cmpCount++; if ((g) !== (e)) begin mismatches++; \
  $display("Error at %0t: got %0h expected %0h", $time, g, e); end end
module rx_clock_recovery_test_mux_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import rcrtm_pkg::*;
  localparam int RD = 512;
  localparam int TT = 1024;
  localparam int BIT_CYC = 16 * int'(DIV_2400);
  localparam int IF_HALF = IF_PERIOD_D1 / 2 + 8;
  logic clk, rst, psel, penable, pwrite, pready, pslverr, er, v, sp;
  logic [7:0] paddr, b;
  logic [31:0] pwdata, prdata, rd, w;
  logic [31:0] seed = 32'h8731;
  logic ifCompIn, testInputPin, txModeIn, supplyLowIn, lockBondedLowIn;
  logic switchedCapClockIn, mixerRefClockIn, rxDataOut, rxtxClockOut, systemClockOut;
  logic testInputEnable, supplyResetNOut, supplyResetNOe, txTimeoutOut, receiveReq;
  rcrtm_mux_t testOutputSel, testInputRoute;
  logic [15:0] history;
  logic [7:0] sampleCount, stableErrs;
  logic [10:0] frame;
  int mismatches = 0;
  int cmpCount = 0;
  int n;

  rcrtm_top #(.RST_DELAY(RD), .TX_TIMEOUT(TT)) i_rcrtm_top (.clk(clk), .rst(rst),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .ifCompIn(ifCompIn),
    .testInputPin(testInputPin), .txModeIn(txModeIn), .supplyLowIn(supplyLowIn),
    .lockBondedLowIn(lockBondedLowIn), .switchedCapClockIn(switchedCapClockIn),
    .mixerRefClockIn(mixerRefClockIn), .rxDataOut(rxDataOut), .rxtxClockOut(rxtxClockOut),
    .systemClockOut(systemClockOut), .testOutputSel(testOutputSel),
    .testInputRoute(testInputRoute), .testInputEnable(testInputEnable),
    .supplyResetNOut(supplyResetNOut), .supplyResetNOe(supplyResetNOe),
    .txTimeoutOut(txTimeoutOut));
  rcrtm_host_model i_rcrtm_host_model (.clk(clk), .rst(rst), .receiveReq(receiveReq),
    .rxData(rxDataOut), .rxtxClock(rxtxClockOut), .txModeIn(txModeIn),
    .history(history), .sampleCount(sampleCount), .stableErrs(stableErrs));

  always #25 clk = ~clk;

  // *****
  // Helpers
  // *****
  function logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  function automatic logic inRange(int x, int lo, int hi);
    return x >= lo && x <= hi;
  endfunction : inRange
  function automatic logic hasByte(logic [15:0] h, logic [7:0] d);
    for (int k = 0; k <= 8; k++) begin
      if (h[k +: 8] === d) return 1'b1;
    end
    return 1'b0;
  endfunction : hasByte
  task automatic closeOut();
    $display("Comparisons %0d, mismatches %0d", cmpCount, mismatches);
    if (mismatches == 0 && cmpCount > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : closeOut
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int k;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      mismatches++;
      closeOut();
    end
    @(posedge clk);
  endtask : apb
  task automatic waitFor(input logic tmo, input logic lvl, input int bound);
    n = 0;
    while (((tmo ? txTimeoutOut : supplyResetNOe) !== lvl) && n < bound) begin
      @(posedge clk);
      n++;
    end
    if (n >= bound) begin
      mismatches++;
      closeOut();
    end
  endtask : waitFor

  // *****
  // Main sequence
  // *****
  initial begin
    {clk, psel, penable, pwrite, paddr, pwdata, ifCompIn, testInputPin} = '0;
    {lockBondedLowIn, switchedCapClockIn, mixerRefClockIn} = '0;
    {rst, supplyLowIn, receiveReq} = 3'b111;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    repeat (3) @(posedge clk);
    `CHK(supplyResetNOe, 1'b1)
    `CHK(supplyResetNOut, 1'b0)
    apb(1'b0, OFS_SETUP, 32'h0);
    `CHK(rd, 32'h0001F2C5)
    apb(1'b0, 8'h10, 32'h0);
    `CHK(er, 1'b1)
    for (int m = 0; m < 4; m++) begin
      w = rnd();
      apb(1'b1, OFS_TEST, {w[31:4], 4'h0} | 32'(m));
      repeat (3) @(posedge clk);
      `CHK(testOutputSel, rcrtm_mux_t'(m))
      `CHK(testInputRoute, rcrtm_mux_t'(m))
      `CHK(testInputEnable, 1'b1)
      apb(1'b0, OFS_STATUS, 32'h0);
      `CHK(rd[9:8], 2'(m))
      for (int s = 0; s < 2; s++) begin
        v = s[0];
        ifCompIn <= (m == 1) ? v : !v;
        switchedCapClockIn <= (m == 2) ? v : !v;
        mixerRefClockIn <= (m == 3) ? v : !v;
        repeat (6) @(posedge clk);
        if (m > 0) `CHK(systemClockOut, v)
        else begin
          sp = systemClockOut;
          @(posedge clk);
          `CHK(systemClockOut, !sp)
        end
      end
    end
    apb(1'b1, OFS_TEST, 32'h8);
    repeat (3) @(posedge clk);
    `CHK(testInputEnable, 1'b0)
    lockBondedLowIn <= 1'b1;
    repeat (4) @(posedge clk);
    apb(1'b1, OFS_SETUP, 32'h12345);
    `CHK(er, 1'b1)
    apb(1'b1, OFS_TEST, 32'h0);
    `CHK(er, 1'b0)
    apb(1'b0, OFS_SETUP, 32'h0);
    `CHK(rd, 32'h0001F2C5)
    lockBondedLowIn <= 1'b0;
    repeat (4) @(posedge clk);
    apb(1'b1, OFS_SETUP, 32'h0002F2C5);
    `CHK(er, 1'b0)
    supplyLowIn <= 1'b0;
    waitFor(1'b0, 1'b0, RD + 40);
    `CHK(inRange(n, RD, RD + 8), 1'b1)
    supplyLowIn <= 1'b1;
    waitFor(1'b0, 1'b1, 8);
    receiveReq <= 1'b0;
    waitFor(1'b1, 1'b1, TT + 40);
    `CHK(inRange(n, TT, TT + 8), 1'b1)
    receiveReq <= 1'b1;
    apb(1'b1, OFS_TEST, 32'h2);
    supplyLowIn <= 1'b0;
    waitFor(1'b0, 1'b0, 40);
    `CHK(inRange(n, RD / SHORT_FACTOR, RD / SHORT_FACTOR + 8), 1'b1)
    supplyLowIn <= 1'b1;
    receiveReq <= 1'b0;
    waitFor(1'b1, 1'b1, 40);
    `CHK(inRange(n, TT / SHORT_FACTOR, TT / SHORT_FACTOR + 8), 1'b1)
    receiveReq <= 1'b1;
    apb(1'b1, OFS_TEST, 32'h0);
    testInputPin <= 1'b1;
    repeat (4) @(posedge clk);
    supplyLowIn <= 1'b0;
    waitFor(1'b0, 1'b0, 8);
    w = rnd();
    b = w[7:0];
    frame = {2'b11, b, 1'b0};
    apb(1'b1, OFS_TEST, 32'h3);
    fork
      for (int i = 0; i < 11; i++) begin
        testInputPin <= frame[i];
        repeat (BIT_CYC) @(posedge clk);
      end
      // Nominal IF period beside the frame
      for (int j = 0; j < 40; j++) begin
        ifCompIn <= !ifCompIn;
        repeat (IF_HALF) @(posedge clk);
      end
    join
    `CHK(hasByte(history, b), 1'b1)
    `CHK(stableErrs, 8'h00)
    apb(1'b1, OFS_TEST, 32'h7);
    apb(1'b0, OFS_STATUS, 32'h0);
    `CHK(rd[3:0], 4'h8)
    `CHK(rd[9:8], 2'h3)
    for (int i = 0; i < 4; i++) begin
      w = rnd();
      testInputPin <= w[0];
      repeat (4) @(posedge clk);
      `CHK(rxDataOut, w[0])
    end
    closeOut();
  end
endmodule : rx_clock_recovery_test_mux_tb_top
